// ---- hdl/pmd_decoder.sv ----
// Summary of operation
// - Command 04 grants status register when host idle.
// - Command 05 drives bus buffer onto host bus.
// - Command 06 puts host bus onto internal bus.
// - Command 07 loads internal bus into buffer.
// - Command 08 requests interrupt, level 1-7, function 0-3.
// - Command 09 requests examine/deposit, level 0, function 4-7.
// - Function word handed over on bus request condition.
// - Bit 51 is the ALU carry input.
// - Bits 52-55 go unchanged to sequencer.
// - Bit 56 stretches microcycle from 4 to 5 clocks, 400 to 500 ns.
// - Spare bits 57 and 58 drive nothing; they count only in parity.
// - Mark bit excluded from parity generate and check.
// - Mark bit never changes other behaviour.
// - Thirty-bit half mux feeds internal bus D06-D35.
// - Upper six bus bits undefined during readout.
// - Mux enabled only by host read command.
// - Command 02 copies buffer 00-17 into status register.
// - Command 03 puts status register on internal bus.
// - Address bit 12 picks right or left half.
module pmd_decoder (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic [pmd_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [pmd_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_we,
  input  wire logic                           reg_re,
  output logic      [pmd_pkg::REG_DATA_W-1:0] reg_rdata,
  input  wire logic [0:pmd_pkg::MW_W-1]       exec_word,
  input  wire logic                           exec_parity,
  output logic                                cycle_start,
  output logic                                alu_carry_in_bit,
  output logic      [3:0]                     sequencer_instr_field,
  output logic                                debug_mark_bit,
  input  wire logic                           host_csr_access,
  output logic                                csr_grant,
  output logic      [0:pmd_pkg::BUS_W-1]      shared_status_reg,
  input  wire logic [0:pmd_pkg::BUS_W-1]      host_io_bus_in,
  output logic      [0:pmd_pkg::BUS_W-1]      host_io_bus_out,
  output logic                                host_io_bus_oe,
  input  wire logic [0:pmd_pkg::BUS_W-1]      internal_bus_in,
  output logic      [0:pmd_pkg::BUS_W-1]      internal_bus_out,
  output logic                                internal_bus_oe,
  input  wire logic                           host_bus_request_cond,
  output logic                                iop_handoff,
  output logic                                req_valid,
  output logic      [2:0]                     req_level,
  output logic      [2:0]                     req_func,
  output logic                                parity_err
);
  import pmd_pkg::*;

  logic [0:MW_W-1]      cur_word;
  logic [2:0]           cyc_cnt;
  logic                 exec_pulse;
  logic                 last_clk;
  pmd_cmd_t             cmd;
  logic [0:BUS_W-1]     bus_buffer_reg;
  logic [0:BUS_W-1]     cmd_bus_data;
  logic                 cmd_bus_drive;
  logic [0:CS_ADDR_W]   control_store_addr_reg;
  logic [0:HALF_W-1]    right_stage;
  logic                 cs_wr;
  logic                 host_read_microword_cmd;
  logic                 control_store_read_enable;
  pmd_rd_state_t        rd_state;
  logic [MW_W:0]        cs_rdata;
  logic [0:MW_W-1]      cs_word;
  logic [0:HALF_W-1]    half_word;
  logic                 stat_clear;

  // Parity over every bit except the debug mark bit.
  function automatic logic mw_parity(input logic [0:MW_W-1] w);
    mw_parity = ^w[0:MARK_BIT-1];
  endfunction

  // Decode one select-field command; unused codes give none.
  function automatic pmd_cmd_t cmd_of(input logic [0:MW_W-1] w);
    logic [9:0] code;
    code = w[MGC_LO:MGC_HI];
    cmd_of = PMD_CMD_NONE;
    if (w[SEL_LO:SEL_HI] == SEL_HOST_BUS) begin
      case (code)
        10'h002: cmd_of = PMD_CMD_LDCSR;
        10'h003: cmd_of = PMD_CMD_RDCSR;
        10'h004: cmd_of = PMD_CMD_REQCSR;
        10'h005: cmd_of = PMD_CMD_DRVBUS;
        10'h006: cmd_of = PMD_CMD_RDBUS;
        10'h007: cmd_of = PMD_CMD_LDBUF;
        10'h008: cmd_of = PMD_CMD_INTR;
        10'h009: cmd_of = PMD_CMD_EXDEP;
        default: cmd_of = PMD_CMD_NONE;
      endcase
    end
  endfunction

  assign last_clk = (cyc_cnt == (cur_word[STRETCH_BIT] ?
                     3'(CYC_STRETCH - 1) : 3'(CYC_NORM - 1)));
  assign cycle_start = last_clk;
  assign exec_pulse  = (cyc_cnt == 3'h0);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cyc_cnt <= 3'h0;
    end else if (last_clk) begin
      cyc_cnt <= 3'h0;
    end else begin
      cyc_cnt <= cyc_cnt + 3'h1;
    end
  end

  // whole word latched, mark bit feeds only its output.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_word <= '0;
    end else if (cycle_start) begin
      cur_word <= exec_word;
    end
  end

  // command decoded from latched word, acts on the first clock after cycle start.
  assign cmd = exec_pulse ? cmd_of(cur_word) : PMD_CMD_NONE;

  assign alu_carry_in_bit = cur_word[CARRY_BIT];
  assign sequencer_instr_field = cur_word[SEQ_LO:SEQ_HI];
  // spare bits are latched but drive nothing.
  assign debug_mark_bit = cur_word[MARK_BIT];

  // parity check excludes the mark bit.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      parity_err <= 1'b0;
    end else if (cycle_start && (mw_parity(exec_word) != exec_parity)) begin
      parity_err <= 1'b1;
    end else if (stat_clear) begin
      parity_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      csr_grant <= 1'b0;
    end else if (cmd == PMD_CMD_REQCSR) begin
      csr_grant <= !host_csr_access;
    end else if (host_csr_access) begin
      csr_grant <= 1'b0;
    end
  end

  // buffer bits 00-17 into status register.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shared_status_reg <= CSR_RESET;
    end else if (cmd == PMD_CMD_LDCSR) begin
      shared_status_reg[0:CSR_LOAD_HI] <= bus_buffer_reg[0:CSR_LOAD_HI];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_buffer_reg <= BUF_RESET;
    end else if (cmd == PMD_CMD_LDBUF) begin
      bus_buffer_reg <= internal_bus_in;
    end
  end

  // internal bus sources for commands 03 and 06.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd_bus_data  <= '0;
      cmd_bus_drive <= 1'b0;
    end else if (cmd == PMD_CMD_RDBUS) begin
      cmd_bus_data  <= host_io_bus_in;
      cmd_bus_drive <= 1'b1;
    end else if (cmd == PMD_CMD_RDCSR) begin
      cmd_bus_data  <= shared_status_reg;
      cmd_bus_drive <= 1'b1;
    end else if (last_clk) begin
      cmd_bus_drive <= 1'b0;
    end
  end

  // buffer onto host bus, also used for the handoff.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_io_bus_out <= '0;
      host_io_bus_oe  <= 1'b0;
    end else if (cmd == PMD_CMD_DRVBUS) begin
      host_io_bus_out <= bus_buffer_reg;
      host_io_bus_oe  <= 1'b1;
    end else if (req_valid && host_bus_request_cond) begin
      host_io_bus_out <= bus_buffer_reg;
      host_io_bus_oe  <= 1'b1;
    end else if (last_clk || iop_handoff) begin
      host_io_bus_oe  <= 1'b0;
    end
  end

  // interrupt request from the function word.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_valid <= 1'b0;
      req_level <= 3'h0;
      req_func  <= 3'h0;
    end else if ((cmd == PMD_CMD_INTR) &&
                 (bus_buffer_reg[IOP_LVL_LO:IOP_LVL_HI] != 3'h0)) begin
      req_valid <= 1'b1;
      req_level <= bus_buffer_reg[IOP_LVL_LO:IOP_LVL_HI];
      req_func  <= {1'b0, bus_buffer_reg[IOP_FUNC_LO:IOP_FUNC_HI]};
    // examine or deposit request at level zero.
    end else if (cmd == PMD_CMD_EXDEP) begin
      req_valid <= 1'b1;
      req_level <= LVL_EXDEP;
      req_func  <= {1'b1, bus_buffer_reg[IOP_FUNC_LO:IOP_FUNC_HI]};
    // handoff on the bus request condition.
    end else if (host_bus_request_cond) begin
      req_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iop_handoff <= 1'b0;
    end else begin
      iop_handoff <= req_valid && host_bus_request_cond;
    end
  end

  // Register port: address, staging, status and readback.
  assign cs_wr = reg_we && (reg_addr == REG_CS_LEFT);
  assign stat_clear = reg_we && (reg_addr == REG_STATUS);
  assign host_read_microword_cmd = reg_we && (reg_addr == REG_CS_READ);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      control_store_addr_reg <= '0;
      right_stage            <= '0;
    end else if (reg_we && (reg_addr == REG_CS_ADDR)) begin
      control_store_addr_reg <= reg_wdata[CS_ADDR_W:0];
    end else if (reg_we && (reg_addr == REG_CS_RIGHT)) begin
      right_stage <= reg_wdata[HALF_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_re && (reg_addr == REG_CS_ADDR)) begin
      reg_rdata <= {19'h0_0000, control_store_addr_reg};
    end else if (reg_re && (reg_addr == REG_STATUS)) begin
      reg_rdata <= {28'h000_0000, req_valid, parity_err,
                    csr_grant, host_io_bus_oe};
    end else begin
      reg_rdata <= '0;
    end
  end

  // read enable only after the host read command.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_state <= PMD_RD_IDLE;
    end else begin
      case (rd_state)
        PMD_RD_IDLE: begin
          if (host_read_microword_cmd) begin
            rd_state <= PMD_RD_FETCH;
          end
        end
        PMD_RD_FETCH: rd_state <= PMD_RD_DRIVE;
        PMD_RD_DRIVE: rd_state <= PMD_RD_IDLE;
        default:      rd_state <= PMD_RD_IDLE;
      endcase
    end
  end

  assign control_store_read_enable = (rd_state == PMD_RD_FETCH);

  // stored parity generated without the mark bit.
  pmd_cstore #(
    .ADDR_W (CS_ADDR_W),
    .DATA_W (MW_W + 1)
  ) u_cstore (
    .clk_sys (clk_sys),
    .wr_en   (cs_wr),
    .wr_addr (control_store_addr_reg[0:CS_ADDR_W-1]),
    .wr_data ({reg_wdata[HALF_W-1:0], right_stage,
               mw_parity({reg_wdata[HALF_W-1:0], right_stage})}),
    .rd_en   (control_store_read_enable),
    .rd_addr (control_store_addr_reg[0:CS_ADDR_W-1]),
    .rd_data (cs_rdata)
  );

  assign cs_word = cs_rdata[MW_W:1];

  // address bit 12 picks the half.
  assign half_word = control_store_addr_reg[HALF_BIT] ?
                     cs_word[0:HALF_W-1] : cs_word[HALF_W:MW_W-1];

  // upper six bits are driven as zero, not promised.
  always_comb begin
    internal_bus_out = cmd_bus_data;
    internal_bus_oe  = cmd_bus_drive;
    if (rd_state == PMD_RD_DRIVE) begin
      internal_bus_out = {6'h00, half_word};
      internal_bus_oe  = 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_grant;
    (cmd == PMD_CMD_REQCSR) && !host_csr_access |=> csr_grant;
  endproperty
  a_grant: assert property (p_grant)
    else $error("status register not granted");

  property p_busy;
    (cmd == PMD_CMD_REQCSR) && host_csr_access |=> !csr_grant;
  endproperty
  a_busy: assert property (p_busy)
    else $error("grant given while host busy");

  property p_drive;
    cmd == PMD_CMD_DRVBUS |=>
      host_io_bus_oe && (host_io_bus_out == $past(bus_buffer_reg));
  endproperty
  a_drive: assert property (p_drive)
    else $error("buffer not on host bus");

  property p_rdbus;
    cmd == PMD_CMD_RDBUS |=>
      internal_bus_oe && (internal_bus_out == $past(host_io_bus_in));
  endproperty
  a_rdbus: assert property (p_rdbus)
    else $error("host bus not on internal bus");

  property p_ldbuf;
    cmd == PMD_CMD_LDBUF |=> bus_buffer_reg == $past(internal_bus_in);
  endproperty
  a_ldbuf: assert property (p_ldbuf)
    else $error("buffer not loaded");

  property p_intr;
    (cmd == PMD_CMD_INTR) &&
    (bus_buffer_reg[IOP_LVL_LO:IOP_LVL_HI] != 3'h0) |=>
      req_valid && (req_level != 3'h0) && !req_func[2];
  endproperty
  a_intr: assert property (p_intr)
    else $error("bad interrupt request");

  property p_exdep;
    cmd == PMD_CMD_EXDEP |=>
      req_valid && (req_level == 3'h0) && req_func[2];
  endproperty
  a_exdep: assert property (p_exdep)
    else $error("bad examine or deposit request");

  property p_hand;
    req_valid && host_bus_request_cond |=>
      iop_handoff && host_io_bus_oe ##1 !iop_handoff;
  endproperty
  a_hand: assert property (p_hand)
    else $error("function word not handed over");

  property p_carry;
    cycle_start |=> alu_carry_in_bit == $past(exec_word[CARRY_BIT]);
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry input wrong");

  property p_norm;
    cycle_start && !exec_word[STRETCH_BIT] |=>
      !cycle_start [*3] ##1 cycle_start;
  endproperty
  a_norm: assert property (p_norm)
    else $error("normal microcycle length wrong");

  property p_stretch;
    cycle_start && exec_word[STRETCH_BIT] |=>
      !cycle_start [*4] ##1 cycle_start;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretched microcycle length wrong");

  property p_rden;
    internal_bus_oe && !cmd_bus_drive |->
      $past(control_store_read_enable) && $past(rd_state == PMD_RD_FETCH);
  endproperty
  a_rden: assert property (p_rden)
    else $error("readout without read enable");

  c_intr: cover property (cmd == PMD_CMD_INTR ##[1:20] iop_handoff);
  c_stretch: cover property (cycle_start && exec_word[STRETCH_BIT]);
  c_readout: cover property (rd_state == PMD_RD_DRIVE);

endmodule

// ---- include/pmd_pkg.sv ----
package pmd_pkg;

  localparam int MW_W        = 60;
  localparam int BUS_W       = 36;
  localparam int HALF_W      = 30;
  localparam int CS_ADDR_W   = 12;
  localparam int REG_ADDR_W  = 8;
  localparam int REG_DATA_W  = 32;

  // Microword field positions, bit 0 is the most significant bit.
  localparam int SEL_LO      = 35;
  localparam int SEL_HI      = 37;
  localparam int MGC_LO      = 24;
  localparam int MGC_HI      = 33;
  localparam int CARRY_BIT   = 51;
  localparam int SEQ_LO      = 52;
  localparam int SEQ_HI      = 55;
  localparam int STRETCH_BIT = 56;
  localparam int SPARE_A_BIT = 57;
  localparam int SPARE_B_BIT = 58;
  localparam int MARK_BIT    = 59;
  localparam int HALF_BIT    = 12;
  localparam int CSR_LOAD_HI = 17;
  localparam int BUS_HALF_LO = 6;

  // Function word fields held in the bus buffer.
  localparam int IOP_FUNC_LO = 1;
  localparam int IOP_FUNC_HI = 2;
  localparam int IOP_LVL_LO  = 3;
  localparam int IOP_LVL_HI  = 5;

  localparam logic [2:0] SEL_HOST_BUS = 3'h5;
  localparam logic [2:0] LVL_EXDEP    = 3'h0;

  typedef enum logic [3:0] {
    PMD_CMD_NONE   = 4'h0,
    PMD_CMD_LDCSR  = 4'h2,
    PMD_CMD_RDCSR  = 4'h3,
    PMD_CMD_REQCSR = 4'h4,
    PMD_CMD_DRVBUS = 4'h5,
    PMD_CMD_RDBUS  = 4'h6,
    PMD_CMD_LDBUF  = 4'h7,
    PMD_CMD_INTR   = 4'h8,
    PMD_CMD_EXDEP  = 4'h9
  } pmd_cmd_t;

  typedef enum logic [1:0] {
    PMD_RD_IDLE  = 2'h0,
    PMD_RD_FETCH = 2'h1,
    PMD_RD_DRIVE = 2'h3
  } pmd_rd_state_t;

  // Microcycle timing.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int CYCLE_NORM_NS    = 320;
  localparam int CYCLE_STRETCH_NS = 480;
  localparam int CYC_NORM =
    (CYCLE_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_STRETCH =
    (CYCLE_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register port offsets and reset values.
  localparam logic [7:0] REG_CS_ADDR  = 8'h00;
  localparam logic [7:0] REG_CS_RIGHT = 8'h04;
  localparam logic [7:0] REG_CS_LEFT  = 8'h08;
  localparam logic [7:0] REG_CS_READ  = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [35:0] CSR_RESET   = 36'h0_0000_0000;
  localparam logic [35:0] BUF_RESET   = 36'h0_0000_0000;

endpackage

// ---- hdl/pmd_cstore.sv ----
module pmd_cstore #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 61
) (
  input  wire logic              clk_sys,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data come out of a register one cycle after the enable.
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- tb/pmd_host_model.sv ----
module pmd_host_model (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      host_drive,
  input  wire logic [0:pmd_pkg::BUS_W-1] host_val,
  input  wire logic [0:pmd_pkg::BUS_W-1] host_io_bus_out,
  input  wire logic                      host_io_bus_oe,
  input  wire logic                      iop_handoff,
  output logic      [0:pmd_pkg::BUS_W-1] host_io_bus_in,
  output logic      [0:pmd_pkg::BUS_W-1] iop_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import pmd_pkg::*;

  logic [0:BUS_W-1] last_bus;

  // A released bus shows the inverse of its last level.
  always_comb begin
    if (host_io_bus_oe) begin
      host_io_bus_in = host_io_bus_out;
    end else if (host_drive) begin
      host_io_bus_in = host_val;
    end else begin
      host_io_bus_in = ~last_bus;
    end
  end

  always_ff @(posedge clk_sys) begin
    last_bus <= host_io_bus_in;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iop_word <= '0;
    end else if (iop_handoff) begin
      iop_word <= host_io_bus_out;
    end
  end
endmodule

// ---- tb/port_microword_field_decoder_tb_top.sv ----
module port_microword_field_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pmd_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic [0:59] exec_word = '0;
  logic        exec_parity = 1'b0;
  logic        cycle_start, alu_carry_in_bit, debug_mark_bit, csr_grant;
  logic        host_io_bus_oe, internal_bus_oe, iop_handoff, req_valid;
  logic        parity_err;
  logic [3:0]  sequencer_instr_field;
  logic [2:0]  req_level, req_func, m_lvl, m_fn;
  logic        host_csr_access = 1'b0;
  logic        host_bus_request_cond = 1'b0;
  logic        host_drive = 1'b0;
  logic [0:35] shared_status_reg, host_io_bus_in, host_io_bus_out, iop_word;
  logic [0:35] internal_bus_out;
  logic [0:35] internal_bus_in = '0;
  logic [0:35] host_val = '0;
  logic [0:35] m_buf = '0;
  logic [0:35] m_csr = '0;
  logic        m_grant = 1'b0;
  logic        m_req = 1'b0;
  logic        m_perr = 1'b0;
  logic [0:59] cs_q[$];
  int          n_errors = 0;
  int          cmp_count = 0;
  int          len_cnt, len_exp;
  bit          len_on;

  always #50 clk_sys = ~clk_sys;

  pmd_decoder pmd_decoder_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .exec_word(exec_word),
    .exec_parity(exec_parity), .cycle_start(cycle_start),
    .alu_carry_in_bit(alu_carry_in_bit),
    .sequencer_instr_field(sequencer_instr_field),
    .debug_mark_bit(debug_mark_bit), .host_csr_access(host_csr_access),
    .csr_grant(csr_grant), .shared_status_reg(shared_status_reg),
    .host_io_bus_in(host_io_bus_in), .host_io_bus_out(host_io_bus_out),
    .host_io_bus_oe(host_io_bus_oe), .internal_bus_in(internal_bus_in),
    .internal_bus_out(internal_bus_out),
    .internal_bus_oe(internal_bus_oe),
    .host_bus_request_cond(host_bus_request_cond),
    .iop_handoff(iop_handoff), .req_valid(req_valid),
    .req_level(req_level), .req_func(req_func), .parity_err(parity_err)
  );

  pmd_host_model pmd_host_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .host_drive(host_drive),
    .host_val(host_val), .host_io_bus_out(host_io_bus_out),
    .host_io_bus_oe(host_io_bus_oe), .iop_handoff(iop_handoff),
    .host_io_bus_in(host_io_bus_in), .iop_word(iop_word)
  );

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] s);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [0:35] rnd36();
    return {4'($urandom), $urandom};
  endfunction

  function automatic logic [0:59] mk(input logic [9:0] c,
                                     input logic [2:0] s);
    logic [0:59] w;
    w = {28'($urandom), $urandom};
    w[MGC_LO:MGC_HI] = c;
    w[SEL_LO:SEL_HI] = s;
    return w;
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic cs_load(input logic [11:0] a, input logic [0:59] w);
    reg_wr(REG_CS_ADDR, 32'({a, 1'b0}));
    reg_wr(REG_CS_RIGHT, 32'(w[30:59]));
    reg_wr(REG_CS_LEFT, 32'(w[0:29]));
  endtask

  task automatic cs_read(input logic [11:0] a, input logic h,
                         input logic [0:29] e);
    reg_wr(REG_CS_ADDR, 32'({a, h}));
    reg_wr(REG_CS_READ, 32'h0000_0000);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("mux_oe", 36'h1, 36'(internal_bus_oe));
    chk("mux", 36'(e), 36'(internal_bus_out[6:35]));
    @(negedge clk_sys);
    chk("mux_off", 36'h0, 36'(internal_bus_oe));
  endtask

  task automatic run_word(input logic [0:59] w, input logic [0:35] ib,
                          input logic hca, input logic bad);
    int          i;
    logic [0:35] hb, eout;
    logic        ehoe, eio;
    hb = rnd36();
    ehoe = 1'b0;
    eio = 1'b0;
    eout = '0;
    i = 0;
    @(posedge clk_sys);
    exec_word <= w;
    exec_parity <= (^w[0:58]) ^ bad;
    host_csr_access <= hca;
    internal_bus_in <= ib;
    host_val <= hb;
    host_drive <= 1'b1;
    do begin
      @(negedge clk_sys);
      i++;
    end while (cycle_start !== 1'b1 && i < 20);
    chk("start", 36'h1, 36'(cycle_start));
    @(posedge clk_sys);
    exec_word <= '0;
    exec_parity <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    host_drive <= 1'b0;
    m_perr = m_perr | bad;
    if (w[SEL_LO:SEL_HI] == SEL_HOST_BUS) begin
      case (w[MGC_LO:MGC_HI])
        10'h002: m_csr[0:17] = m_buf[0:17];
        10'h003: begin eio = 1'b1; eout = m_csr; end
        10'h004: m_grant = !hca;
        10'h005: ehoe = 1'b1;
        10'h006: begin eio = 1'b1; eout = hb; end
        10'h007: m_buf = ib;
        10'h008: if (m_buf[3:5] != 3'h0) begin
          m_req = 1'b1;
          m_lvl = m_buf[3:5];
          m_fn = {1'b0, m_buf[1:2]};
        end
        10'h009: begin
          m_req = 1'b1;
          m_lvl = LVL_EXDEP;
          m_fn = {1'b1, m_buf[1:2]};
        end
        default: ;
      endcase
    end
    if (hca) m_grant = 1'b0;
    chk("csr", m_csr, shared_status_reg);
    chk("grant", 36'(m_grant), 36'(csr_grant));
    chk("host_oe", 36'(ehoe), 36'(host_io_bus_oe));
    if (ehoe) chk("host_out", m_buf, host_io_bus_out);
    chk("int_oe", 36'(eio), 36'(internal_bus_oe));
    if (eio) chk("int_out", eout, internal_bus_out);
    chk("req", 36'(m_req), 36'(req_valid));
    if (m_req) begin
      chk("lvl", 36'(m_lvl), 36'(req_level));
      chk("fn", 36'(m_fn), 36'(req_func));
    end
    chk("carry", 36'(w[CARRY_BIT]), 36'(alu_carry_in_bit));
    chk("seq", 36'(w[SEQ_LO:SEQ_HI]), 36'(sequencer_instr_field));
    chk("mark", 36'(w[MARK_BIT]), 36'(debug_mark_bit));
    chk("perr", 36'(m_perr), 36'(parity_err));
  endtask

  task automatic handoff;
    @(posedge clk_sys);
    host_bus_request_cond <= 1'b1;
    @(posedge clk_sys);
    host_bus_request_cond <= 1'b0;
    @(negedge clk_sys);
    m_req = 1'b0;
    chk("hand", 36'h1, 36'({iop_handoff, host_io_bus_oe} == 2'b11));
    chk("hand_word", m_buf, host_io_bus_out);
    chk("hand_req", 36'h0, 36'(req_valid));
    @(negedge clk_sys);
    chk("hand_end", 36'h0, 36'(iop_handoff));
    chk("host_word", m_buf, iop_word);
  endtask

  always @(negedge clk_sys) begin
    if (!rst_n) begin
      len_cnt = 0;
      len_on = 1'b0;
    end else begin
      len_cnt++;
      if (cycle_start === 1'b1) begin
        if (len_on) chk("len", 36'(len_exp), 36'(len_cnt));
        len_exp = exec_word[STRETCH_BIT] ? CYC_STRETCH : CYC_NORM;
        len_on = 1'b1;
        len_cnt = 0;
      end
    end
  end

  initial begin
    #3_000_000;
    n_errors++;
    tally_and_finish;
  end

  initial begin
    int          k;
    logic [31:0] d;
    logic [0:35] ib;
    logic [0:59] w;
    int          codes[13] = '{7, 5, 2, 3, 6, 4, 4, 4, 8, 9, 1, 10, 1023};
    bit          hcas[13] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0};
    void'($urandom(32'hc82b));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("rst", 36'h0, 36'({csr_grant, req_valid, parity_err}));
    for (k = 0; k < 2; k++) begin
      w = mk(10'h000, 3'h0);
      cs_q.push_back(w);
      cs_load(12'(k * 5 + 1), w);
    end
    for (k = 0; k < 4; k++) begin
      cs_read(12'((k / 2) * 5 + 1), k[0],
              k[0] ? cs_q[k / 2][0:29] : cs_q[k / 2][30:59]);
    end
    ib = rnd36();
    ib[3:5] = 3'h6;
    for (k = 0; k < 13; k++) begin
      run_word(mk(10'(codes[k]), SEL_HOST_BUS), ib, hcas[k], 1'b0);
      if (m_req) handoff;
    end
    run_word(mk(10'h005, 3'h4), ib, 1'b0, 1'b0);
    for (k = 0; k < 40; k++) begin
      w = mk(10'($urandom % 12),
             ($urandom % 4 == 0) ? 3'($urandom) : SEL_HOST_BUS);
      run_word(w, rnd36(), ($urandom % 3) == 0, 1'b0);
      if (m_req && ($urandom % 2 == 1)) handoff;
    end
    run_word(mk(10'h000, 3'h0), rnd36(), 1'b0, 1'b1);
    reg_rd(REG_STATUS, d);
    chk("stat", 36'({m_req, m_perr, m_grant, 1'b0}), 36'(d[3:0]));
    reg_wr(REG_STATUS, 32'h0000_0000);
    m_perr = 1'b0;
    reg_rd(REG_STATUS, d);
    chk("stat_clr", 36'({m_req, 1'b0, m_grant, 1'b0}), 36'(d[3:0]));
    reg_rd(8'h14, d);
    chk("unmapped", 36'h0, 36'(d));
    tally_and_finish;
  end
endmodule
